// ### pkg/pmic_regs_pkg.sv
`default_nettype none
//==========================================================
// Shared constants and types
//==========================================================
package pmic_regs_pkg;

	// Bus widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_STANDBY  = 8'hEA;
	localparam logic [7:0] IDX_CRIT     = 8'hEB;
	localparam logic [7:0] IDX_HOT      = 8'hEC;
	localparam logic [7:0] IDX_OVERRIDE = 8'hEE;

	// Byte addresses on the bus
	localparam logic [11:0] ADDR_STANDBY    = {2'h0, IDX_STANDBY, 2'h0};
	localparam logic [11:0] ADDR_CRIT       = {2'h0, IDX_CRIT, 2'h0};
	localparam logic [11:0] ADDR_HOT        = {2'h0, IDX_HOT, 2'h0};
	localparam logic [11:0] ADDR_OVERRIDE   = {2'h0, IDX_OVERRIDE, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h400;
	localparam logic [11:0] ADDR_IRQ_MASK   = 12'h404;

	// Standby control layout
	localparam logic [7:0] STANDBY_RESET   = 8'hFE;
	localparam logic [4:0] STANDBY_RSVD    = 5'h1F;
	localparam int         SB_CUR_SRC_BIT  = 2;
	localparam int         SB_COMP_BIT     = 1;
	localparam int         SB_IGN_PG_BIT   = 0;

	// Temperature flag layout: bit 5 linear regulator, bit 0 regulator one
	localparam int         FLAG_W     = 6;
	localparam logic [5:0] FLAG_RESET = 6'h00;

	// Pin override layout: one bit per rail
	localparam int         NUM_RAILS = 8;
	localparam logic [7:0] OVR_RESET = 8'h00;

	// Interrupt layout: [5:0] critical events, [11:6] hot events
	localparam int          IRQ_W     = 12;
	localparam logic [11:0] IRQ_RESET = 12'h000;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Thermal conditions from the regulators
	typedef struct packed {
		logic [5:0] hot;
		logic [5:0] crit;
	} thermal_t;

endpackage : pmic_regs_pkg
`default_nettype wire

// ### verilog/temp_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none
//==========================================================
// Sticky write-one-to-clear flag bank
//==========================================================
module temp_flag_bank
	import pmic_regs_pkg::*;
#(
	parameter int W = 6
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Condition levels and clear strobes
	input  wire logic [W-1:0] cond,
	input  wire logic [W-1:0] clr,
	// Flag state and new-assertion events
	output logic      [W-1:0] flags,
	output logic      [W-1:0] rise
);

	// Next flag value: a live condition wins over a clear
	logic [W-1:0] next_flags;

	assign next_flags = (flags & ~clr) | cond;
	// Event only when a clear flag is newly set
	assign rise = cond & ~flags;

	//==========================================================
	// Flag register
	//==========================================================
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			flags <= '0;
		else
			flags <= next_flags;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// A condition always shows up in the flags one cycle later
	flag_set_a : assert property ((cond != '0) |=> ((flags & $past(cond)) == $past(cond)))
		else $error("flag not set by condition");
	// A flag without clear never drops
	flag_keep_a : assert property ((clr == '0) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag dropped without clear");

endmodule : temp_flag_bank
`default_nettype wire

// ### verilog/pmic_standby_thermal_override_regs.sv
`timescale 1ns/1ns
`default_nettype none
//==========================================================
//==========================================================
module pmic_standby_thermal_override_regs
	import pmic_regs_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// AXI4-Lite write address
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [ADDR_W-1:0]    awaddr,
	// AXI4-Lite write data
	input  wire logic                 wvalid,
	output logic                      wready,
	input  wire logic [DATA_W-1:0]    wdata,
	input  wire logic [3:0]           wstrb,
	// AXI4-Lite write response
	output logic                      bvalid,
	input  wire logic                 bready,
	output logic      [1:0]           bresp,
	// AXI4-Lite read address
	input  wire logic                 arvalid,
	output logic                      arready,
	input  wire logic [ADDR_W-1:0]    araddr,
	// AXI4-Lite read data
	output logic                      rvalid,
	input  wire logic                 rready,
	output logic      [DATA_W-1:0]    rdata,
	output logic      [1:0]           rresp,
	// Regulator thermal conditions
	input  wire thermal_t             temp_cond,
	// Rail enable control
	input  wire logic [NUM_RAILS-1:0] rail_enable_pin,
	input  wire logic [NUM_RAILS-1:0] rail_enable_pin_mask,
	input  wire logic [NUM_RAILS-1:0] rail_reg_enable,
	output logic      [NUM_RAILS-1:0] rail_enable,
	// Standby qualification
	input  wire logic                 sleep_s0_n,
	input  wire logic                 delayed_all_system_power_good,
	output logic                      quick_standby_n,
	// Compensation controls
	output logic                      comp_current_source_enable,
	output logic                      compensation_enable,
	// Interrupt
	output logic                      irq
);

	//==========================================================
	// Storage
	//==========================================================
	logic [2:0]           standby;        // Writable standby bits
	logic [NUM_RAILS-1:0] override;       // Rail force-on bits
	logic [IRQ_W-1:0]     irq_status;     // Sticky events
	logic [IRQ_W-1:0]     irq_mask;       // Event enables
	logic [FLAG_W-1:0]    crit_flags;     // Critical flags
	logic [FLAG_W-1:0]    hot_flags;      // Hot flags
	logic [FLAG_W-1:0]    crit_rise;      // New critical events
	logic [FLAG_W-1:0]    hot_rise;       // New hot events

	// Write channel holding registers and last read address
	logic                 aw_full;        // Address captured
	logic [ADDR_W-1:0]    aw_addr_q;      // Captured address
	logic                 w_full;         // Data captured
	logic [DATA_W-1:0]    w_data_q;       // Captured data
	logic [3:0]           w_strb_q;       // Captured strobes
	logic [ADDR_W-1:0]    rd_addr_q;      // Address of last read

	//==========================================================
	// Handshakes and decode
	//==========================================================
	logic wr_do;          // Both halves present, response free
	logic rd_fire;        // Read address taken
	logic wr_sel_sb;
	logic wr_sel_crit;
	logic wr_sel_hot;
	logic wr_sel_ovr;
	logic wr_sel_isr;
	logic wr_sel_imr;
	logic wr_hit;
	logic rd_hit;
	logic rd_clear_isr;   // Read of status clears it
	logic [DATA_W-1:0] rd_word;
	logic [FLAG_W-1:0] crit_clr;
	logic [FLAG_W-1:0] hot_clr;
	logic [IRQ_W-1:0]  events;
	logic [IRQ_W-1:0]  next_irq_status;
	logic [IRQ_W-1:0]  next_irq_mask;
	logic [NUM_RAILS-1:0] next_rail_enable;
	logic              next_quick_standby_n;

	// Each channel accepts one item until it is consumed
	assign awready = !aw_full;
	assign wready  = !w_full;
	assign arready = !rvalid;
	// Write waits until any earlier response has gone
	assign wr_do   = aw_full && w_full && !bvalid;
	assign rd_fire = arvalid && arready;

	// Write address decode
	assign wr_sel_sb   = (aw_addr_q == ADDR_STANDBY);
	assign wr_sel_crit = (aw_addr_q == ADDR_CRIT);
	assign wr_sel_hot  = (aw_addr_q == ADDR_HOT);
	assign wr_sel_ovr  = (aw_addr_q == ADDR_OVERRIDE);
	assign wr_sel_isr  = (aw_addr_q == ADDR_IRQ_STATUS);
	assign wr_sel_imr  = (aw_addr_q == ADDR_IRQ_MASK);
	assign wr_hit = wr_sel_sb || wr_sel_crit || wr_sel_hot
		|| wr_sel_ovr || wr_sel_isr || wr_sel_imr;

	// Read mux; unmapped words read zero with an error answer
	assign rd_word =
		(araddr == ADDR_STANDBY)    ? {24'h0, STANDBY_RSVD, standby} :
		(araddr == ADDR_CRIT)       ? {26'h0, crit_flags} :
		(araddr == ADDR_HOT)        ? {26'h0, hot_flags} :
		(araddr == ADDR_OVERRIDE)   ? {24'h0, override} :
		(araddr == ADDR_IRQ_STATUS) ? {20'h0, irq_status} :
		(araddr == ADDR_IRQ_MASK)   ? {20'h0, irq_mask} : 32'h0;
	assign rd_hit = (araddr == ADDR_STANDBY) || (araddr == ADDR_CRIT)
		|| (araddr == ADDR_HOT) || (araddr == ADDR_OVERRIDE)
		|| (araddr == ADDR_IRQ_STATUS) || (araddr == ADDR_IRQ_MASK);
	assign rd_clear_isr = rd_fire && (araddr == ADDR_IRQ_STATUS);

	// Write-one clears; zero bits and bits 7:6 never reach the flags
	assign crit_clr = (wr_do && wr_sel_crit && w_strb_q[0]) ? w_data_q[5:0] : '0;
	assign hot_clr  = (wr_do && wr_sel_hot && w_strb_q[0]) ? w_data_q[5:0] : '0;

	// Events set status; a clear by read loses to a fresh event
	assign events = {hot_rise, crit_rise};
	assign next_irq_status = (rd_clear_isr ? '0 : irq_status) | events;
	assign next_irq_mask = {
		(wr_do && wr_sel_imr && w_strb_q[1]) ? w_data_q[11:8] : irq_mask[11:8],
		(wr_do && wr_sel_imr && w_strb_q[0]) ? w_data_q[7:0] : irq_mask[7:0]};
	assign irq = |(irq_status & irq_mask);

	// Mask high hands the rail to register control elsewhere
	assign next_rail_enable = (rail_enable_pin_mask & rail_reg_enable)
		| (~rail_enable_pin_mask & override)
		| (~rail_enable_pin_mask & ~override & rail_enable_pin);

	// Standby detect: low sleep, qualified by delayed good unless ignored
	assign next_quick_standby_n = sleep_s0_n ||
		!(standby[SB_IGN_PG_BIT] || delayed_all_system_power_good);

	assign comp_current_source_enable = standby[SB_CUR_SRC_BIT];
	assign compensation_enable        = standby[SB_COMP_BIT];

	//==========================================================
	// Flag banks
	//==========================================================
	temp_flag_bank #(
		.W     (FLAG_W)
	) u_crit (
		.clk   (clk),
		.rst_b (rst_b),
		.cond  (temp_cond.crit),
		.clr   (crit_clr),
		.flags (crit_flags),
		.rise  (crit_rise)
	);

	temp_flag_bank #(
		.W     (FLAG_W)
	) u_hot (
		.clk   (clk),
		.rst_b (rst_b),
		.cond  (temp_cond.hot),
		.clr   (hot_clr),
		.flags (hot_flags),
		.rise  (hot_rise)
	);

	//==========================================================
	// Write address and data capture
	//==========================================================
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			aw_full   <= 1'b0;
			aw_addr_q <= '0;
			w_full    <= 1'b0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end
		else
		begin
			// Halves may arrive in either order
			if (awvalid && awready)
			begin
				aw_full   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			else if (wr_do)
				aw_full <= 1'b0;
			if (wvalid && wready)
			begin
				w_full   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			else if (wr_do)
				w_full <= 1'b0;
		end
	end

	//==========================================================
	// Write response
	//==========================================================
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	//==========================================================
	// Read answer
	//==========================================================
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rvalid    <= 1'b0;
			rdata     <= '0;
			rresp     <= RESP_OKAY;
			rd_addr_q <= '0;
		end
		else if (rd_fire)
		begin
			rvalid    <= 1'b1;
			rdata     <= rd_word;
			rresp     <= rd_hit ? RESP_OKAY : RESP_DECERR;
			rd_addr_q <= araddr;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	//==========================================================
	// Control registers
	//==========================================================
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			standby  <= STANDBY_RESET[2:0];
			override <= OVR_RESET;
		end
		else if (wr_do && w_strb_q[0])
		begin
			// Bits 7:3 of standby are not stored, so writes cannot touch them
			if (wr_sel_sb)
				standby <= w_data_q[2:0];
			else if (wr_sel_ovr)
				override <= w_data_q[7:0];
		end
	end

	//==========================================================
	// Interrupt registers
	//==========================================================
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			irq_status <= IRQ_RESET;
			irq_mask   <= IRQ_RESET;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
		end
	end

	//==========================================================
	// Registered outputs to the power stage
	//==========================================================
	// One cycle of latency keeps pin glitches off the rails
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rail_enable     <= '0;
			quick_standby_n <= 1'b1;
		end
		else
		begin
			rail_enable     <= next_rail_enable;
			quick_standby_n <= next_quick_standby_n;
		end
	end

	//==========================================================
	// Checks
	//==========================================================
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence sb_write;
		wr_do && wr_sel_sb && w_strb_q[0];
	endsequence

	sequence crit_clear_only;
		(crit_clr != '0) && (temp_cond.crit == '0);
	endsequence

	rsvd_ones_a : assert property (rvalid && rd_addr_q == ADDR_STANDBY |-> rdata[7:3] == 5'h1F)
		else $error("standby reserved bits not one");
	cur_src_a : assert property (sb_write |=> comp_current_source_enable == $past(w_data_q[2]))
		else $error("current source enable mismatch");
	comp_en_a : assert property (sb_write |=> compensation_enable == $past(w_data_q[1]))
		else $error("compensation enable mismatch");
	standby_qual_a : assert property ((!sleep_s0_n && !standby[0]
		&& !delayed_all_system_power_good) |=> quick_standby_n)
		else $error("standby detected without delayed good");
	standby_ign_a : assert property ((!sleep_s0_n && standby[0]) |=> !quick_standby_n)
		else $error("standby not detected while ignoring good");
	crit_rsvd_a : assert property (rvalid && rd_addr_q == ADDR_CRIT |-> rdata[31:6] == '0)
		else $error("critical reserved bits not zero");
	crit_clear_a : assert property (crit_clear_only |=> (crit_flags & $past(crit_clr)) == '0)
		else $error("critical flag not cleared");
	hot_set_a : assert property ((temp_cond.hot != '0)
		|=> (hot_flags & $past(temp_cond.hot)) == $past(temp_cond.hot))
		else $error("hot flag not set");
	pin_follow_a : assert property (1'b1 |=> ((rail_enable ^ $past(rail_enable_pin))
		& ~$past(override) & ~$past(rail_enable_pin_mask)) == '0)
		else $error("rail not following pin");
	force_on_a : assert property (1'b1 |=> (~rail_enable & $past(override)
		& ~$past(rail_enable_pin_mask)) == '0)
		else $error("rail not forced on");
	zero_write_a : assert property (wr_do && (wr_sel_crit || wr_sel_hot) && w_data_q[5:0] == '0
		|=> crit_flags == ($past(crit_flags) | $past(temp_cond.crit)))
		else $error("zero write changed flags");
	irq_event_a : assert property ((events != '0) |=> (irq_status & $past(events)) == $past(events))
		else $error("event not recorded in status");

endmodule : pmic_standby_thermal_override_regs
`default_nettype wire

// ### tb/pmic_standby_thermal_override_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pmic_standby_thermal_override_regs_tb
	import pmic_regs_pkg::*;
;
	//==========================================================
	// Signals
	//==========================================================
	logic                 clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic                 awready, wready, bvalid, arready, rvalid, irq;
	logic                 sleep_s0_n, delayed_all_system_power_good, quick_standby_n;
	logic                 comp_current_source_enable, compensation_enable;
	logic [ADDR_W-1:0]    awaddr, araddr;
	logic [DATA_W-1:0]    wdata, rdata;
	logic [3:0]           wstrb;
	logic [1:0]           bresp, rresp;
	thermal_t             temp_cond;
	logic [NUM_RAILS-1:0] rail_enable_pin, rail_enable_pin_mask, rail_reg_enable, rail_enable;
	// Expected response notes, oldest first
	typedef struct packed {
		logic        wr;
		logic [31:0] data;
		logic [1:0]  resp;
	} note_t;
	note_t                exp_q[$];
	note_t                head;
	int                   error_cnt, cmp_count, cyc;
	logic [31:0]          seed, v, p, m;
	logic [11:0]          a;
	logic [2:0]           k;

	pmic_standby_thermal_override_regs dut (.clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .temp_cond(temp_cond),
		.rail_enable_pin(rail_enable_pin), .rail_enable_pin_mask(rail_enable_pin_mask),
		.rail_reg_enable(rail_reg_enable), .rail_enable(rail_enable), .sleep_s0_n(sleep_s0_n),
		.delayed_all_system_power_good(delayed_all_system_power_good), .quick_standby_n(quick_standby_n),
		.comp_current_source_enable(comp_current_source_enable),
		.compensation_enable(compensation_enable), .irq(irq));

	//==========================================================
	// Helpers
	//==========================================================
	// Free-running 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Xorshift keeps the stimulus repeatable from a fixed seed
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// One comparison, counted
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	// Write: address and data offered together; bready stays high afterwards,
	// so a following call never drives it twice in one time step
	task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
		logic aw_p, w_p, b_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		b_p = 1'b1;
		exp_q.push_back({1'b1, 32'h00000000, er});
		awaddr <= ad;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (b_p)
		begin
			@(posedge clk);
			if (aw_p && awready)
			begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready)
			begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
			b_p = !bvalid;
		end
	endtask : wr

	// Read: rready raised with the request and left high, the monitor compares the data
	task automatic rd(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
		logic ar_p, r_p;
		ar_p = 1'b1;
		r_p = 1'b1;
		exp_q.push_back({1'b0, d, er});
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (r_p)
		begin
			@(posedge clk);
			if (ar_p && arready)
			begin
				ar_p = 1'b0;
				arvalid <= 1'b0;
			end
			r_p = !rvalid;
		end
	endtask : rd

	// Verdict and end of run
	task automatic test_done();
		$display("compares %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// Monitor: each completed response is matched against the oldest note
	always @(posedge clk)
	begin
		if (rst_b && ((bvalid && bready) || (rvalid && rready)))
		begin
			if (exp_q.size() == 0)
				chk(32'h1, 32'h0, "response with no note");
			else
			begin
				head = exp_q.pop_front();
				if (head.wr)
					chk(32'(bresp), 32'(head.resp), "write response");
				else
				begin
					chk(rdata, head.data, "read data");
					chk(32'(rresp), 32'(head.resp), "read response");
				end
			end
		end
	end

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("mismatch at %0t: timeout", $time);
			test_done();
		end
	end

	//==========================================================
	// Main sequence
	//==========================================================
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, delayed_all_system_power_good} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		{temp_cond, rail_enable_pin, rail_enable_pin_mask, rail_reg_enable} = '0;
		sleep_s0_n = 1'b1;
		rst_b = 1'b0;
		seed = 32'h000019FF;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// Reset state of outputs and registers
		chk(32'({comp_current_source_enable, compensation_enable}), 32'h3, "comp reset");
		chk(32'({rail_enable, quick_standby_n, irq}), 32'h002, "output reset");
		rd(ADDR_STANDBY, 32'h000000FE, RESP_OKAY);
		rd(ADDR_CRIT, 32'h00000000, RESP_OKAY);
		rd(ADDR_HOT, 32'h00000000, RESP_OKAY);
		rd(ADDR_OVERRIDE, 32'h00000000, RESP_OKAY);
		rd(ADDR_IRQ_MASK, 32'h00000000, RESP_OKAY);
		rd(12'h010, 32'h00000000, RESP_DECERR);
		wr(12'h010, 32'h000000FF, RESP_DECERR);
		$display("test reset done");
		// Reserved bits stay one while writable bits follow the write
		wr(ADDR_STANDBY, 32'h00000000, RESP_OKAY);
		rd(ADDR_STANDBY, 32'h000000F8, RESP_OKAY);
		chk(32'({comp_current_source_enable, compensation_enable}), 32'h0, "comp off");
		wr(ADDR_STANDBY, 32'h00000007, RESP_OKAY);
		rd(ADDR_STANDBY, 32'h000000FF, RESP_OKAY);
		chk(32'({comp_current_source_enable, compensation_enable}), 32'h3, "comp on");
		// Standby detection over every input combination, both ignore settings
		for (int i = 0; i < 8; i++)
		begin
			k = i[2:0];
			if (k[1:0] == 2'h0)
				wr(ADDR_STANDBY, 32'(3'h6 | k[2]), RESP_OKAY);
			sleep_s0_n <= k[0];
			delayed_all_system_power_good <= k[1];
			repeat (3) @(posedge clk);
			chk(32'(quick_standby_n), 32'(k[0] | !(k[2] | k[1])), "standby detect");
		end
		$display("test standby done");
		// Sticky flags: live condition beats a clear, zeros and reserved ignored
		wr(ADDR_IRQ_MASK, 32'h00000FFF, RESP_OKAY);
		for (int r = 0; r < 2; r++)
		begin
			v = rnd() % 6;
			m = 32'h1 << v;
			a = (r == 1) ? ADDR_HOT : ADDR_CRIT;
			if (r == 1)
				temp_cond.hot[v] <= 1'b1;
			else
				temp_cond.crit[v] <= 1'b1;
			repeat (2) @(posedge clk);
			wr(a, m, RESP_OKAY);
			temp_cond <= '0;
			repeat (2) @(posedge clk);
			rd(a, m, RESP_OKAY);
			chk(32'(irq), 32'h1, "irq raised");
			rd(ADDR_IRQ_STATUS, m << (6 * r), RESP_OKAY);
			chk(32'(irq), 32'h0, "irq cleared");
			wr(a, 32'hC0 | (~m & 32'h3F), RESP_OKAY);
			rd(a, m, RESP_OKAY);
			wr(a, m, RESP_OKAY);
			rd(a, 32'h00000000, RESP_OKAY);
		end
		// Masked event still recorded but keeps irq low
		wr(ADDR_IRQ_MASK, 32'h00000000, RESP_OKAY);
		temp_cond.crit[0] <= 1'b1;
		repeat (2) @(posedge clk);
		temp_cond <= '0;
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0, "irq masked");
		rd(ADDR_IRQ_STATUS, 32'h00000001, RESP_OKAY);
		wr(ADDR_CRIT, 32'h00000001, RESP_OKAY);
		rd(ADDR_CRIT, 32'h00000000, RESP_OKAY);
		$display("test flags done");
		// Rail override against random pins, masks and register enables
		for (int i = 0; i < 8; i++)
		begin
			v = rnd();
			wr(ADDR_OVERRIDE, 32'(v[7:0]), RESP_OKAY);
			rd(ADDR_OVERRIDE, 32'(v[7:0]), RESP_OKAY);
			p = rnd();
			rail_enable_pin <= p[7:0];
			rail_enable_pin_mask <= p[15:8];
			rail_reg_enable <= p[23:16];
			repeat (3) @(posedge clk);
			chk(32'(rail_enable), 32'((p[15:8] & p[23:16]) | (~p[15:8] & (p[7:0] | v[7:0]))), "rails");
		end
		$display("test override done");
		test_done();
	end

endmodule : pmic_standby_thermal_override_regs_tb
`default_nettype wire
